// *** isc_pkg.sv ***
// Package for the instrument status and clear block
// Assumes a single 50 MHz clock and a synchronous active-high reset
package isc_pkg;
    // Standard event bit positions
    localparam int EV_OPC = 0;
    localparam int EV_QUERY = 2;
    localparam int EV_DEVICE = 3;
    localparam int EV_EXEC = 4;
    localparam int EV_CMD = 5;
    localparam int EV_PON = 7;
    // Bits of the standard event register that can ever be set
    localparam logic [7:0] EV_USED_MASK = 8'hbd;
    // Status byte bit positions
    localparam int SB_ERRQ = 2;
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;
    localparam int SB_MSS = 6;
    // Status byte bits that the service request mask may select
    localparam logic [7:0] SB_USED_MASK = 8'h34;
    // Reset values
    localparam logic [7:0] EV_RESET = 8'h80;
    localparam logic [7:0] ENA_RESET = 8'h00;
    // Error queue depth, and count width less one (the count is ERRQ_AW+1 bits)
    localparam int ERRQ_DEPTH = 16;
    localparam int ERRQ_AW = 4;
    // Settle time after a device clear, in ms, and in cycles at 50 MHz
    localparam int CLK_HZ = 50000000;
    localparam int CLEAR_WAIT_MS = 2000;
    localparam longint CLEAR_WAIT_CYC =
        (64'(CLEAR_WAIT_MS) * 64'(CLK_HZ)) / 64'd1000;

    // Common commands as seen by the status logic
    typedef struct packed {
        logic clear_status;
        logic read_event;
        logic write_event_ena;
        logic write_srq_ena;
        logic opc_done;
        logic [7:0] data;
    } isc_cmd_t;

    // Error reports from the parser and execution engine
    typedef struct packed {
        logic query_err;
        logic device_err;
        logic exec_err;
        logic cmd_err;
    } isc_err_t;

    // Actions requested by a device clear
    typedef struct packed {
        logic abort_meas;
        logic trig_idle;
        logic flush_in;
        logic flush_out;
        logic parser_reset;
        logic cancel_overlap;
    } isc_clr_t;

    typedef enum logic [1:0] {
        ISC_IDLE,
        ISC_CLEAR,
        ISC_READY
    } isc_clr_state_t;
endpackage

// *** isc_err_count.sv ***
// Error queue occupancy tracker
// Assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module isc_err_count (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Queue traffic
    input wire logic push,
    input wire logic pop,
    // Occupancy
    output logic not_empty,
    output logic full
);
    logic [isc_pkg::ERRQ_AW:0] count;

    always_ff @(posedge clock) begin
        if (srst) begin
            count <= '0;
        end else if (push && !pop && !full) begin
            count <= count + 1'b1;
        end else if (pop && !push && count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign not_empty = (count != '0);
    assign full = (count == (isc_pkg::ERRQ_AW + 1)'(isc_pkg::ERRQ_DEPTH));
endmodule
`default_nettype wire

// *** isc_status.sv ***
// Status reporting and device clear handling for a remote instrument
// Assumes command decode and the bus interface sit outside on the same clock
// What this block does
// (R1) Device clear aborts any running measurement.
// (R2) Device clear returns the trigger machine to idle.
// (R3) Device clear empties the input and output buffers.
// (R4) After device clear the parser is ready for a fresh command string.
// (R5) Device clear leaves status, error queue and settings untouched.
// (R6) Device clear ends an overlapped command without operation complete.
// (R7) Controller should wait two seconds after device clear before traffic.
// (R8) Condition bits follow live state, unlatched, read without clearing.
// (R9) Event bits latch events; further events while set are ignored.
// (R10) Event bits stay set until queried or cleared by clear-status.
// (R11) Enable masks are readable, writable and select summary contributors.
// (R12) Event bit 0 is operation complete; bits 1 and 6 read zero.
// (R13) Event bit 2 flags query errors, bit 3 device errors.
// (R14) Event bit 4 flags execution errors, bit 5 command errors.
// (R15) Event bit 7 shows power cycled since the last read or clear.
// (R16) Clear-status or the event query clears the standard event register.
// (R17) The event enable mask takes the written value; zero clears it.
// (R18) Clearing a group event or clear-status clears status byte bits.
// (R19) Status byte bit 4 shows output data waiting; bits 0,1,3,7 zero.
// (R20) Status byte bit 2 shows a non-empty error queue.
// (R21) Status byte bit 5 summarises enabled standard event bits.
// (R22) Status byte bit 6 summarises enabled status bits, may request service.
// (R23) Each summary is the OR of event AND enable, every clock.
`timescale 1ns/1ps
`default_nettype none
module isc_status #(
    parameter longint CLEAR_WAIT = isc_pkg::CLEAR_WAIT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Common commands and device clear
    input wire isc_pkg::isc_cmd_t cmd,
    input wire logic dev_clear,
    // Event and condition sources
    input wire isc_pkg::isc_err_t err,
    input wire logic power_on,
    input wire logic out_data_waiting,
    input wire logic err_pop,
    // Register read-back
    output logic [7:0] event_read,
    output logic [7:0] event_ena,
    output logic [7:0] srq_ena,
    output logic [7:0] status_byte,
    // Service request, clear actions and error queue full flag
    output logic srq,
    output isc_pkg::isc_clr_t clr_act,
    output logic clear_busy,
    output logic err_q_full
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] standard_event_latch;
    logic [7:0] next_event;
    logic [7:0] ev_in;
    logic errq_ne;
    logic errq_full;
    logic err_push;
    logic errq_clear;
    logic mav;
    logic esb;
    logic [7:0] sb_cond;
    logic mss;
    logic [63:0] wait_cnt;
    isc_pkg::isc_clr_state_t clr_state;
    logic power_seen;

    assign err_push = |err;
    // Clear-status empties the queue; an error in that same cycle is lost
    assign errq_clear = srst || cmd.clear_status; // [R18]

    isc_err_count u_errq (
        .clock(clock),
        .srst(errq_clear),
        .push(err_push),
        .pop(err_pop),
        .not_empty(errq_ne),
        .full(errq_full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event inputs, operation complete suppressed during a clear
    always_comb begin
        ev_in = 8'h00;
        ev_in[isc_pkg::EV_OPC] = cmd.opc_done && !dev_clear; // [R12] [R6]
        ev_in[isc_pkg::EV_QUERY] = err.query_err; // [R13]
        ev_in[isc_pkg::EV_DEVICE] = err.device_err; // [R13]
        ev_in[isc_pkg::EV_EXEC] = err.exec_err; // [R14]
        ev_in[isc_pkg::EV_CMD] = err.cmd_err; // [R14]
        ev_in[isc_pkg::EV_PON] = power_on && !power_seen; // [R15]
    end

    // Set wins over clear so an event in the clear cycle is kept
    always_comb begin
        next_event = standard_event_latch;
        if (cmd.clear_status || cmd.read_event) begin
            next_event = 8'h00; // [R16]
        end
        next_event = (next_event | ev_in) & isc_pkg::EV_USED_MASK; // [R9]
    end

    // Device clear does not touch the latch [R5]
    always_ff @(posedge clock) begin
        if (srst) begin
            standard_event_latch <= isc_pkg::EV_RESET; // [R15]
        end else begin
            standard_event_latch <= next_event; // [R10]
        end
    end

    // Power-on is reported once per power cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            power_seen <= 1'b1;
        end else if (!power_on) begin
            power_seen <= 1'b0;
        end else if (ev_in[isc_pkg::EV_PON]) begin
            power_seen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable masks
    always_ff @(posedge clock) begin
        if (srst) begin
            event_ena <= isc_pkg::ENA_RESET;
        end else if (cmd.write_event_ena) begin
            event_ena <= cmd.data; // [R17] [R11]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            srq_ena <= isc_pkg::ENA_RESET;
        end else if (cmd.write_srq_ena) begin
            srq_ena <= cmd.data & isc_pkg::SB_USED_MASK; // [R22] [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte, live condition bits [R8]
    assign mav = out_data_waiting && !clr_act.flush_out; // [R19] [R8]
    assign esb = |(next_event & event_ena); // [R21] [R23] [R18]

    always_comb begin
        sb_cond = 8'h00;
        sb_cond[isc_pkg::SB_ERRQ] = errq_ne; // [R20]
        sb_cond[isc_pkg::SB_MAV] = mav; // [R19]
        sb_cond[isc_pkg::SB_ESB] = esb; // [R21]
    end
    assign mss = |(sb_cond & srq_ena); // [R22] [R23]

    always_ff @(posedge clock) begin
        if (srst) begin
            status_byte <= 8'h00;
            srq <= 1'b0;
            event_read <= 8'h00;
            err_q_full <= 1'b0;
        end else begin
            status_byte <= sb_cond | ({7'h00, mss} << isc_pkg::SB_MSS);
            srq <= mss; // [R22]
            event_read <= standard_event_latch;
            err_q_full <= errq_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device clear sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            clr_state <= isc_pkg::ISC_IDLE;
            wait_cnt <= '0;
        end else begin
            case (clr_state)
                isc_pkg::ISC_IDLE: begin
                    if (dev_clear) begin
                        clr_state <= isc_pkg::ISC_CLEAR;
                    end
                end
                isc_pkg::ISC_CLEAR: begin
                    clr_state <= isc_pkg::ISC_READY;
                    wait_cnt <= 64'(CLEAR_WAIT - 1);
                end
                isc_pkg::ISC_READY: begin
                    // Settle window the controller is expected to honour
                    if (dev_clear) begin
                        clr_state <= isc_pkg::ISC_CLEAR;
                    end else if (wait_cnt == '0) begin
                        clr_state <= isc_pkg::ISC_IDLE; // [R7]
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                default: begin
                    clr_state <= isc_pkg::ISC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            clr_act <= '0;
            clear_busy <= 1'b0;
        end else begin
            clr_act.abort_meas <= dev_clear; // [R1]
            clr_act.trig_idle <= dev_clear; // [R2]
            clr_act.flush_in <= dev_clear; // [R3]
            clr_act.flush_out <= dev_clear; // [R3]
            clr_act.parser_reset <= dev_clear; // [R4]
            clr_act.cancel_overlap <= dev_clear; // [R6]
            clear_busy <= dev_clear || clr_state != isc_pkg::ISC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_clear_actions: assert property ( // [R1] [R2] [R3] [R4] [R6]
        @(posedge clock) disable iff (srst)
        dev_clear |=> clr_act.abort_meas && clr_act.trig_idle
            && clr_act.flush_in && clr_act.flush_out
            && clr_act.parser_reset && clr_act.cancel_overlap)
        else $error("device clear actions missing");
    chk_clear_pulse: assert property ( // [R1] [R3]
        @(posedge clock) disable iff (srst)
        !dev_clear |=> clr_act == '0)
        else $error("clear action longer than one cycle");
    chk_clear_no_opc: assert property ( // [R6]
        @(posedge clock) disable iff (srst)
        dev_clear && !cmd.clear_status && !cmd.read_event
        && !standard_event_latch[0] |=> !standard_event_latch[0])
        else $error("operation complete set during clear");
    chk_clear_keeps: assert property ( // [R5]
        @(posedge clock) disable iff (srst)
        dev_clear && !cmd.write_event_ena && !cmd.write_srq_ena
        |=> $stable(event_ena) && $stable(srq_ena))
        else $error("device clear changed a mask");
    chk_busy_start: assert property ( // [R7]
        @(posedge clock) disable iff (srst)
        dev_clear |=> clear_busy)
        else $error("clear busy missing");
    chk_event_hold: assert property ( // [R9] [R10]
        @(posedge clock) disable iff (srst)
        (standard_event_latch != 8'h00) && !cmd.clear_status
        && !cmd.read_event |=> ($past(standard_event_latch)
        & ~standard_event_latch) == 8'h00)
        else $error("event bit dropped without clear");
    chk_event_clear: assert property ( // [R16]
        @(posedge clock) disable iff (srst)
        (cmd.clear_status || cmd.read_event) && ev_in == 8'h00
        |=> standard_event_latch == 8'h00)
        else $error("event register not cleared");
    chk_event_zero: assert property ( // [R12]
        @(posedge clock) disable iff (srst)
        standard_event_latch[1] == 1'b0
        && standard_event_latch[6] == 1'b0)
        else $error("unused event bits set");
    chk_opc_event: assert property ( // [R12]
        @(posedge clock) disable iff (srst)
        cmd.opc_done && !dev_clear |=> standard_event_latch[0])
        else $error("operation complete not latched");
    chk_query_err: assert property ( // [R13]
        @(posedge clock) disable iff (srst)
        err.query_err |=> standard_event_latch[2])
        else $error("query error not latched");
    chk_device_err: assert property ( // [R13]
        @(posedge clock) disable iff (srst)
        err.device_err |=> standard_event_latch[3])
        else $error("device error not latched");
    chk_exec_err: assert property ( // [R14]
        @(posedge clock) disable iff (srst)
        err.exec_err |=> standard_event_latch[4])
        else $error("execution error not latched");
    chk_cmd_err: assert property ( // [R14]
        @(posedge clock) disable iff (srst)
        err.cmd_err |=> standard_event_latch[5])
        else $error("command error not latched");
    chk_power_event: assert property ( // [R15]
        @(posedge clock) disable iff (srst)
        !power_on ##1 power_on |=> standard_event_latch[7])
        else $error("power cycle not latched");
    chk_ese_write: assert property ( // [R17] [R11]
        @(posedge clock) disable iff (srst)
        cmd.write_event_ena |=> event_ena == $past(cmd.data))
        else $error("event enable not written");
    chk_sre_mask: assert property ( // [R22] [R11]
        @(posedge clock) disable iff (srst)
        cmd.write_srq_ena
        |=> srq_ena == ($past(cmd.data) & isc_pkg::SB_USED_MASK))
        else $error("service request enable not written");
    chk_mav_bit: assert property ( // [R19]
        @(posedge clock) disable iff (srst)
        out_data_waiting && !clr_act.flush_out |=> status_byte[4])
        else $error("message available missing");
    chk_sb_zero: assert property ( // [R19]
        @(posedge clock) disable iff (srst)
        (status_byte & 8'h8b) == 8'h00)
        else $error("unused status bits set");
    chk_errq_bit: assert property ( // [R20]
        @(posedge clock) disable iff (srst)
        err_push && !err_pop && !cmd.clear_status |=> ##1 status_byte[2])
        else $error("error queue bit missing");
    chk_status_clear: assert property ( // [R18]
        @(posedge clock) disable iff (srst)
        cmd.clear_status && ev_in == 8'h00
        |=> !status_byte[5] ##1 !status_byte[2])
        else $error("clear status left status bits");
    chk_esb_sum: assert property ( // [R21] [R23]
        @(posedge clock) disable iff (srst)
        status_byte[5] == |(standard_event_latch & $past(event_ena)))
        else $error("event summary wrong");
    chk_srq_sum: assert property ( // [R22] [R23]
        @(posedge clock) disable iff (srst)
        srq == |(status_byte & $past(srq_ena)) && status_byte[6] == srq)
        else $error("service request mismatch");

    cov_dev_clear: cover property (@(posedge clock) dev_clear ##1 clear_busy);
    cov_srq: cover property (@(posedge clock) !srq ##1 srq);
    cov_esr_read: cover property (@(posedge clock)
        standard_event_latch != 8'h00 ##1 cmd.read_event);
    cov_errq_full: cover property (@(posedge clock) !err_q_full ##1 err_q_full);
    cov_power: cover property (@(posedge clock) !power_on ##1 power_on);
endmodule
`default_nettype wire

// *** isc_ctrl_model.sv ***
// Bus controller model: issues common commands and device clear messages
// Assumes callers enter its tasks 1 ns after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl_model (
    // Clock
    input wire logic clock,
    // Device side
    input wire logic clear_busy,
    // Bus commands
    output var isc_pkg::isc_cmd_t cmd,
    output var logic dev_clear
);
    initial begin
        cmd = '0;
        dev_clear = 1'b0;
    end

    // Kind 0 clear status, 1 event query, 2 and 3 mask writes, 4 opc
    task automatic send(input int kind, input logic [7:0] value);
        cmd = isc_pkg::isc_cmd_t'({5'(5'b10000 >> kind), value});
        @(posedge clock);
        #1;
        cmd = '0;
    endtask

    task automatic clear_msg(input logic with_opc);
        dev_clear = 1'b1;
        cmd.opc_done = with_opc;
        @(posedge clock);
        #1;
        dev_clear = 1'b0;
        cmd = '0;
    endtask

    // Hold off traffic after a clear until clear_busy falls, for at most 200 cycles
    task automatic settle;
        for (int i = 0; i < 200 && clear_busy; i++) begin
            @(posedge clock);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the status and clear block
// Assumes the controller model drives commands; bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    isc_pkg::isc_cmd_t cmd;
    logic dev_clear;
    isc_pkg::isc_err_t err = '0;
    logic power_on = 1'b1;
    logic out_data_waiting = 1'b0;
    logic err_pop = 1'b0;
    logic [7:0] event_read, event_ena, srq_ena, status_byte;
    logic srq, clear_busy, err_q_full;
    isc_pkg::isc_clr_t clr_act;
    int err_count = 0;
    int total_checks = 0;
    int nerr = 0;
    logic [31:0] seed = 32'h49b8;
    logic [7:0] ena, sre, ev, sb;

    initial forever #10 clock = ~clock;

    isc_status #(.CLEAR_WAIT(20)) u_isc_status (.clock(clock), .srst(srst),
        .cmd(cmd), .dev_clear(dev_clear), .err(err), .power_on(power_on),
        .out_data_waiting(out_data_waiting), .err_pop(err_pop),
        .event_read(event_read), .event_ena(event_ena), .srq_ena(srq_ena),
        .status_byte(status_byte), .srq(srq), .clr_act(clr_act),
        .clear_busy(clear_busy), .err_q_full(err_q_full));
    isc_ctrl_model u_isc_ctrl_model (.clock(clock), .clear_busy(clear_busy),
        .cmd(cmd), .dev_clear(dev_clear));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] expect_sb(input logic [7:0] e, input
        logic mav, input logic errq);
        logic [7:0] r;
        r = 8'h00;
        r[2] = errq;
        r[4] = mav;
        r[5] = |(e & ena);
        r[6] = |(r & sre & 8'h34);
        return r;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // Kind 0 query, 1 device, 2 execution, 3 command error
    task automatic pulse_err(input int kind);
        err = isc_pkg::isc_err_t'(4'b1000 >> kind);
        nerr++;
        step(1);
        err = '0;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(5);
        srst = 1'b0;
        step(1);
        check(event_ena, 8'h00);
        check(srq_ena, 8'h00);
        check(status_byte, 8'h00);
        check(event_read, 8'h80);
        u_isc_ctrl_model.send(1, 8'h00);
        step(1);
        check(event_read, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            seed = xorshift(seed);
            ena = seed[7:0];
            sre = seed[15:8];
            u_isc_ctrl_model.send(2, ena);
            step(1);
            u_isc_ctrl_model.send(3, sre);
            step(1);
            check(event_ena, ena);
            check(srq_ena, sre & 8'h34);
            if (i % 5 == 4) begin
                u_isc_ctrl_model.send(4, 8'h00);
                ev = 8'h01;
            end else begin
                pulse_err(i % 5);
                ev = 8'h04 << (i % 5);
            end
            step(1);
            check(event_read, ev);
            sb = expect_sb(ev, 1'b0, nerr > 0);
            check(status_byte, sb);
            check({7'h00, srq}, {7'h00, sb[6]});
            u_isc_ctrl_model.send(1, 8'h00);
            step(1);
            check(status_byte, expect_sb(8'h00, 1'b0, 1'b1));
        end
        out_data_waiting = 1'b1;
        step(2);
        check(status_byte, expect_sb(8'h00, 1'b1, 1'b1));
        out_data_waiting = 1'b0;
        $display("event and summary test done");
        pulse_err(2);
        step(1);
        u_isc_ctrl_model.clear_msg(1'b1);
        check(8'(clr_act), 8'h3f);
        check({7'h00, clear_busy}, 8'h01);
        step(1);
        check(8'(clr_act), 8'h00);
        u_isc_ctrl_model.settle();
        check({7'h00, clear_busy}, 8'h00);
        check(event_ena, ena);
        check(srq_ena, sre & 8'h34);
        check(status_byte, expect_sb(8'h10, 1'b0, 1'b1));
        check(event_read, 8'h10);
        u_isc_ctrl_model.send(0, 8'h00);
        // Clear-status also empties the error queue
        nerr = 0;
        step(1);
        check(event_read, 8'h00);
        check(status_byte, 8'h00);
        $display("device clear test done");
        while (nerr < 18) begin
            pulse_err(3);
            step(1);
        end
        step(2);
        check({7'h00, err_q_full}, 8'h01);
        err_pop = 1'b1;
        step(16);
        err_pop = 1'b0;
        step(2);
        check({7'h00, err_q_full}, 8'h00);
        check(status_byte & 8'h04, 8'h00);
        power_on = 1'b0;
        step(2);
        power_on = 1'b1;
        step(3);
        check(event_read & 8'h80, 8'h80);
        $display("queue and power test done");
        results();
    end
endmodule
`default_nettype wire
